/* logic/pic_dev.sv */
// programmable interrupt controller, device end
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module pic_dev
  import pic_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  pic_if.dev bus,
  input wire logic [7:0] request_lines_in,
  input wire logic [2:0] cascade_id_in,
  input wire logic master_select_in,
  output logic [2:0] cascade_id_out,
  output logic cascade_out_valid_n_out,
  output logic buffer_dir_out,
  output logic buffer_dir_valid_n_out
);
  typedef struct packed {
    pic_init_t init_st;
    logic init_done;
    logic ic4;
    logic sngl;
    logic adi;
    logic ltim;
    logic [2:0] icw1_hi;
    logic [7:0] vec_base;
    logic [7:0] icw3;
    logic vector_mode;
    logic aeoi;
    logic buf_ms;
    logic buf_mode;
    logic [7:0] imr;
    logic [7:0] irr;
    logic [7:0] isr;
    logic [7:0] line_prev;
    logic [2:0] low_pri;
    logic rot_aeoi;
    logic read_isr;
    logic poll;
    logic prev_wr;
    logic prev_rd;
    logic prev_ack;
    logic [1:0] ack_cnt;
    logic [2:0] ack_idx;
    logic ack_mine;
    logic ack_slave;
    logic ack_drive;
    logic [2:0] cas_id;
    logic cas_valid;
    logic [7:0] dout;
    logic dvalid;
    logic irq;
    logic [7:0] req_s1;
    logic [7:0] req_s2;
    logic ms_s1;
    logic ms_s2;
  } pic_dev_state_t;

  pic_dev_state_t q_reg, q_next;

  logic [7:0] d;
  logic adr0;
  logic wr_go, rd_on, rd_go, ack_go, sel, cascaded, master;
  logic [3:0] req_w, isr_w;
  logic [7:0] irr_clr, rise_en;
  logic [1:0] last_pulse;

  always_comb begin
    q_next = q_reg;
    d = bus.write_bus_in;
    adr0 = bus.addr_bit_zero;
    irr_clr = 8'h00;
    rise_en = 8'hFF;
    sel = 1'b0;
    q_next.req_s1 = request_lines_in;
    q_next.req_s2 = q_reg.req_s1;
    q_next.ms_s1 = master_select_in;
    q_next.ms_s2 = q_reg.ms_s1;
    q_next.line_prev = q_reg.req_s2;
    q_next.prev_wr = bus.write_strobe_n;
    q_next.prev_rd = bus.read_strobe_n;
    q_next.prev_ack = bus.ack_strobe_n;
    cascaded = !q_reg.sngl;
    master = q_reg.buf_mode ? q_reg.buf_ms : q_reg.ms_s2;
    last_pulse = q_reg.vector_mode ? VEC_PULSES : CALL_PULSES;
    wr_go = !bus.select_n && !bus.write_strobe_n && q_reg.prev_wr;
    rd_on = !bus.select_n && !bus.read_strobe_n && q_reg.init_done;
    rd_go = rd_on && q_reg.prev_rd;
    ack_go = !bus.ack_strobe_n && q_reg.prev_ack && q_reg.init_done;
    req_w = pic_pick(q_reg.irr & ~q_reg.imr, q_reg.low_pri);
    isr_w = pic_pick(q_reg.isr, q_reg.low_pri);
    q_next.dvalid = 1'b0;

    if (wr_go) begin
      if (!adr0 && d[ICW1_SEL_BIT]) begin
        q_next.ic4 = d[ICW1_IC4];
        q_next.sngl = d[ICW1_SNGL];
        q_next.adi = d[ICW1_ADI];
        q_next.ltim = d[ICW1_LTIM];
        q_next.icw1_hi = d[7:5];
        q_next.init_st = PIC_IS_ICW2;
        q_next.init_done = 1'b0;
        q_next.imr = 8'h00;
        q_next.isr = 8'h00;
        q_next.low_pri = LOW_PRI_RST;
        q_next.read_isr = 1'b0;
        q_next.poll = 1'b0;
        q_next.rot_aeoi = 1'b0;
        q_next.vector_mode = 1'b0;
        q_next.aeoi = 1'b0;
        q_next.buf_mode = 1'b0;
        q_next.buf_ms = 1'b0;
        q_next.ack_cnt = 2'h0;
        // with edge mode both before and after, a line already high must rise again before it counts
        irr_clr = 8'hFF;
        rise_en = 8'h00;
      end else if (q_reg.init_st != PIC_IS_READY) begin
        if (adr0) begin
          unique case (q_reg.init_st)
            PIC_IS_ICW2: begin
              q_next.vec_base = d;
              q_next.init_st = !q_reg.sngl ? PIC_IS_ICW3 :
                               (q_reg.ic4 ? PIC_IS_ICW4 : PIC_IS_READY);
            end
            PIC_IS_ICW3: begin
              q_next.icw3 = d;
              q_next.init_st = q_reg.ic4 ? PIC_IS_ICW4 : PIC_IS_READY;
            end
            PIC_IS_ICW4: begin
              q_next.vector_mode = d[ICW4_VEC];
              q_next.aeoi = d[ICW4_AEOI];
              q_next.buf_ms = d[ICW4_MS];
              q_next.buf_mode = d[ICW4_BUF];
              q_next.init_st = PIC_IS_READY;
            end
            default: q_next.init_st = PIC_IS_READY;
          endcase
          q_next.init_done = (q_next.init_st == PIC_IS_READY);
        end
      end else if (q_reg.init_done) begin
        if (adr0) begin
          q_next.imr = d;
        end else if (d[OCW3_SEL_BIT]) begin
          q_next.poll = d[OCW3_POLL];
          if (d[OCW3_RR]) q_next.read_isr = d[OCW3_RIS];
        end else begin
          unique case (d[7:5])
            OCW2_NS_EOI: if (isr_w[3]) q_next.isr[isr_w[2:0]] = 1'b0;
            OCW2_LVL_EOI: q_next.isr[d[2:0]] = 1'b0;
            OCW2_ROT_NS: begin
              if (isr_w[3]) begin
                q_next.isr[isr_w[2:0]] = 1'b0;
                q_next.low_pri = isr_w[2:0];
              end
            end
            OCW2_ROT_LVL: begin
              q_next.isr[d[2:0]] = 1'b0;
              q_next.low_pri = d[2:0];
            end
            OCW2_SET_PRI: q_next.low_pri = d[2:0];
            OCW2_ROT_AEOI_SET: q_next.rot_aeoi = 1'b1;
            OCW2_ROT_AEOI_CLR: q_next.rot_aeoi = 1'b0;
            default: q_next.rot_aeoi = q_reg.rot_aeoi;
          endcase
        end
      end
    end

    if (rd_on) begin
      q_next.dvalid = 1'b1;
      if (rd_go) begin
        if (q_reg.poll && !adr0) begin
          // a poll read acts like the first acknowledge pulse
          q_next.dout = {req_w[3], 4'h0, req_w[2:0]};
          if (req_w[3]) begin
            q_next.isr[req_w[2:0]] = 1'b1;
            irr_clr[req_w[2:0]] = 1'b1;
          end
          q_next.poll = 1'b0;
        end else begin
          q_next.dout = adr0 ? q_reg.imr : (q_reg.read_isr ? q_reg.isr : q_reg.irr);
        end
      end
    end

    if (ack_go) begin
      q_next.ack_cnt = q_reg.ack_cnt + 2'h1;
      if (q_reg.ack_cnt == 2'h0) begin
        q_next.ack_idx = req_w[3] ? req_w[2:0] : SPURIOUS_LEVEL;
        q_next.ack_mine = req_w[3];
        q_next.ack_slave = cascaded && master && req_w[3] && q_reg.icw3[req_w[2:0]];
        if (!cascaded || master) begin
          if (req_w[3]) begin
            q_next.isr[req_w[2:0]] = 1'b1;
            irr_clr[req_w[2:0]] = 1'b1;
          end
          if (q_next.ack_slave) begin
            q_next.cas_id = req_w[2:0];
            q_next.cas_valid = 1'b1;
          end
          if (!q_reg.vector_mode) begin
            q_next.dout = CALL_OPCODE;
            q_next.dvalid = 1'b1;
            q_next.ack_drive = 1'b1;
          end
        end
      end else begin
        sel = !cascaded || (master && !q_reg.ack_slave) ||
              (!master && q_reg.ack_mine && cascade_id_in == q_reg.icw3[2:0]);
        if (sel) begin
          if (!q_reg.vector_mode && q_reg.ack_cnt == 2'h1) begin
            q_next.dout = q_reg.adi ? {q_reg.icw1_hi, q_reg.ack_idx, 2'h0} :
                          {q_reg.icw1_hi[2:1], q_reg.ack_idx, 3'h0};
          end else if (q_reg.vector_mode) begin
            q_next.dout = {q_reg.vec_base[7:3], q_reg.ack_idx};
          end else begin
            q_next.dout = q_reg.vec_base;
          end
          q_next.dvalid = 1'b1;
          q_next.ack_drive = 1'b1;
          if (cascaded && !master && q_reg.ack_cnt == 2'h1) begin
            q_next.isr[q_reg.ack_idx] = 1'b1;
            irr_clr[q_reg.ack_idx] = 1'b1;
          end
        end
        if (q_reg.ack_cnt + 2'h1 == last_pulse) begin
          q_next.ack_cnt = 2'h0;
          if (q_reg.aeoi && q_reg.ack_mine) begin
            q_next.isr[q_reg.ack_idx] = 1'b0;
            if (q_reg.rot_aeoi) q_next.low_pri = q_reg.ack_idx;
          end
        end
      end
    end else if (!bus.ack_strobe_n && q_reg.ack_drive) begin
      q_next.dvalid = 1'b1;
    end else if (bus.ack_strobe_n) begin
      q_next.ack_drive = 1'b0;
      if (q_reg.ack_cnt == 2'h0) q_next.cas_valid = 1'b0;
    end

    // a fresh rise in an acknowledge or poll clearing cycle still latches
    if (q_reg.ltim) begin
      q_next.irr = q_reg.req_s2;
    end else begin
      q_next.irr = (q_reg.irr & ~irr_clr & q_reg.req_s2) |
                   (q_reg.req_s2 & ~q_reg.line_prev & rise_en);
    end

    q_next.irq = q_reg.init_done && req_w[3] && q_reg.ack_cnt == 2'h0 && !ack_go &&
                 (!isr_w[3] || pic_rank(req_w[2:0], q_reg.low_pri) <
                  pic_rank(isr_w[2:0], q_reg.low_pri));
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_reg <= '0;
      q_reg.init_st <= PIC_IS_READY;
      q_reg.low_pri <= LOW_PRI_RST;
      q_reg.prev_wr <= 1'b1;
      q_reg.prev_rd <= 1'b1;
      q_reg.prev_ack <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign bus.read_bus = q_reg.dout;
  assign bus.read_bus_valid = q_reg.dvalid;
  assign bus.int_req = q_reg.irq;
  assign cascade_id_out = q_reg.cas_id;
  assign cascade_out_valid_n_out = ~q_reg.cas_valid;
  // low opens the transceivers toward the cpu while this unit drives data
  assign buffer_dir_out = ~q_reg.dvalid;
  assign buffer_dir_valid_n_out = ~(q_reg.buf_mode && q_reg.init_done);
endmodule // pic_dev
`default_nettype wire

/* logic/pic_pkg.sv */
// constants, enumerations and helper functions of the interrupt controller
package pic_pkg;
  localparam int ICW1_SEL_BIT = 4;
  localparam int OCW3_SEL_BIT = 3;
  localparam int ICW1_IC4 = 0;
  localparam int ICW1_SNGL = 1;
  localparam int ICW1_ADI = 2;
  localparam int ICW1_LTIM = 3;
  localparam int ICW4_VEC = 0;
  localparam int ICW4_AEOI = 1;
  localparam int ICW4_MS = 2;
  localparam int ICW4_BUF = 3;
  localparam int OCW3_POLL = 2;
  localparam int OCW3_RR = 1;
  localparam int OCW3_RIS = 0;
  localparam logic [2:0] OCW2_NS_EOI = 3'h1;
  localparam logic [2:0] OCW2_LVL_EOI = 3'h3;
  localparam logic [2:0] OCW2_ROT_NS = 3'h5;
  localparam logic [2:0] OCW2_ROT_AEOI_SET = 3'h4;
  localparam logic [2:0] OCW2_ROT_AEOI_CLR = 3'h0;
  localparam logic [2:0] OCW2_ROT_LVL = 3'h7;
  localparam logic [2:0] OCW2_SET_PRI = 3'h6;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [2:0] LOW_PRI_RST = 3'h7;
  localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
  localparam logic [1:0] VEC_PULSES = 2'h2;
  localparam logic [1:0] CALL_PULSES = 2'h3;
  // host controller register offsets and pin timing
  localparam logic [3:0] HREG_WRITE = 4'h0;
  localparam logic [3:0] HREG_READ = 4'h1;
  localparam logic [3:0] HREG_ACK = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_BYTE0 = 4'h4;
  localparam logic [1:0] STROBE_LOW_CYC = 2'h2;

  typedef enum logic [3:0] {
    PIC_IS_READY = 4'b0001,
    PIC_IS_ICW2 = 4'b0010,
    PIC_IS_ICW3 = 4'b0100,
    PIC_IS_ICW4 = 4'b1000
  } pic_init_t;

  typedef enum logic [3:0] {
    PIC_HS_IDLE = 4'b0001,
    PIC_HS_LOW = 4'b0010,
    PIC_HS_GAP = 4'b0100,
    PIC_HS_DONE = 4'b1000
  } pic_hstate_t;

  // winner of a vector under rotating priority: {found, level}
  function automatic logic [3:0] pic_pick(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      k = low + 3'(i) + 3'h1;
      if (v[k]) r = {1'b1, k};
    end
    return r;
  endfunction

  // priority rank, zero is highest
  function automatic logic [2:0] pic_rank(input logic [2:0] lvl, input logic [2:0] low);
    return lvl - low - 3'h1;
  endfunction
endpackage

/* logic/pic_if.sv */
// cpu-side pin bundle between the controller and its host
`timescale 1ns/100ps
`default_nettype none
interface pic_if;
  logic addr_bit_zero;
  logic select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic ack_strobe_n;
  logic [7:0] write_bus_in;
  logic [7:0] read_bus;
  logic read_bus_valid;
  logic int_req;

  modport dev (
    input addr_bit_zero, select_n, read_strobe_n, write_strobe_n, ack_strobe_n, write_bus_in,
    output read_bus, read_bus_valid, int_req
  );
  modport host (
    output addr_bit_zero, select_n, read_strobe_n, write_strobe_n, ack_strobe_n, write_bus_in,
    input read_bus, read_bus_valid, int_req
  );
endinterface
`default_nettype wire

/* logic/pic_host.sv */
// host end: turns register orders into controller pin cycles
`timescale 1ns/100ps
`default_nettype none
module pic_host
  import pic_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  pic_if.host bus,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out
);
  typedef struct packed {
    pic_hstate_t st;
    logic [1:0] kind;
    logic [1:0] cyc;
    logic [1:0] pulses;
    logic [1:0] pulse_idx;
    logic adr0;
    logic [7:0] wbyte;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic [2:0][7:0] res;
    logic [15:0] rdata;
  } pic_host_state_t;

  localparam logic [1:0] KIND_WR = 2'h0;
  localparam logic [1:0] KIND_RD = 2'h1;
  localparam logic [1:0] KIND_ACK = 2'h2;

  pic_host_state_t q_reg, q_next;
  logic busy;

  always_comb begin
    q_next = q_reg;
    busy = (q_reg.st != PIC_HS_IDLE);
    q_next.rdata = 16'h0000;
    if (rd_in) begin
      if (addr_in == HREG_STATUS) begin
        q_next.rdata = {14'h0000, bus.int_req, busy};
      end else if (addr_in >= HREG_BYTE0 && addr_in < HREG_BYTE0 + 4'h3) begin
        q_next.rdata = {8'h00, q_reg.res[2'(addr_in - HREG_BYTE0)]};
      end
    end
    // orders arriving while a cycle runs are dropped
    if (wr_in && !busy && addr_in <= HREG_ACK) begin
      q_next.st = PIC_HS_LOW;
      q_next.cyc = 2'h0;
      q_next.adr0 = wdata_in[8];
      q_next.wbyte = wdata_in[7:0];
      q_next.pulse_idx = 2'h0;
      q_next.res = '0;
      q_next.kind = addr_in[1:0];
      q_next.pulses = (wdata_in[0] ? CALL_PULSES : VEC_PULSES);
      q_next.sel_n = (addr_in == HREG_ACK);
      q_next.wr_n = (addr_in != HREG_WRITE);
      q_next.rd_n = (addr_in != HREG_READ);
      q_next.ack_n = (addr_in != HREG_ACK);
    end else begin
      unique case (q_reg.st)
        PIC_HS_IDLE: q_next.st = PIC_HS_IDLE;
        PIC_HS_LOW: begin
          q_next.cyc = q_reg.cyc + 2'h1;
          if (q_reg.cyc + 2'h1 == STROBE_LOW_CYC) begin
            if (bus.read_bus_valid && q_reg.kind != KIND_WR) begin
              q_next.res[q_reg.pulse_idx] = bus.read_bus;
            end
            q_next.sel_n = 1'b1;
            q_next.wr_n = 1'b1;
            q_next.rd_n = 1'b1;
            q_next.ack_n = 1'b1;
            q_next.pulse_idx = q_reg.pulse_idx + 2'h1;
            q_next.st = (q_reg.kind == KIND_ACK && q_reg.pulse_idx + 2'h1 < q_reg.pulses) ?
                        PIC_HS_GAP : PIC_HS_DONE;
          end
        end
        PIC_HS_GAP: begin
          q_next.st = PIC_HS_LOW;
          q_next.cyc = 2'h0;
          q_next.ack_n = 1'b0;
        end
        PIC_HS_DONE: q_next.st = PIC_HS_IDLE;
        default: q_next.st = PIC_HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_reg <= '0;
      q_reg.st <= PIC_HS_IDLE;
      q_reg.kind <= KIND_RD;
      q_reg.sel_n <= 1'b1;
      q_reg.rd_n <= 1'b1;
      q_reg.wr_n <= 1'b1;
      q_reg.ack_n <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign bus.addr_bit_zero = q_reg.adr0;
  assign bus.select_n = q_reg.sel_n;
  assign bus.read_strobe_n = q_reg.rd_n;
  assign bus.write_strobe_n = q_reg.wr_n;
  assign bus.ack_strobe_n = q_reg.ack_n;
  assign bus.write_bus_in = q_reg.wbyte;
  assign rdata_out = q_reg.rdata;
endmodule // pic_host
`default_nettype wire

/* bench/pic_chk.sv */
// concurrent checks on the pin bundle between host end and controller end, and on the request, master select, cascade and buffer pins
`timescale 1ns/100ps
`default_nettype none
module pic_chk (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic ack_strobe_n,
  input wire logic [7:0] read_bus,
  input wire logic read_bus_valid,
  input wire logic int_req,
  input wire logic [7:0] request_lines_in,
  input wire logic master_select_in,
  input wire logic cascade_out_valid_n_out,
  input wire logic buffer_dir_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  property p_dir;
    buffer_dir_out == !read_bus_valid;
  endproperty
  a_dir: assert property (p_dir) else $error("buffer direction wrong");
  property p_valid_cause;
    $rose(read_bus_valid) |-> $past(!ack_strobe_n) || $past(!read_strobe_n && !select_n);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("data valid without strobe");
  property p_valid_end;
    $fell(read_bus_valid) |-> $past(read_strobe_n) && $past(ack_strobe_n);
  endproperty
  a_valid_end: assert property (p_valid_end) else $error("data valid dropped early");
  property p_ack_clears;
    $fell(ack_strobe_n) && int_req |-> ##[1:3] !int_req;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("interrupt kept after ack");
  property p_data_stable;
    read_bus_valid && $past(read_bus_valid) |-> $stable(read_bus);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while valid");
  property p_write_quiet;
    !write_strobe_n && !select_n |-> !read_bus_valid;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("data driven on write");
  property p_cascade_master;
    !cascade_out_valid_n_out |-> master_select_in;
  endproperty
  a_cascade_master: assert property (p_cascade_master) else $error("slave drove cascade");
  property p_int_cause;
    $rose(int_req) |-> $past(request_lines_in, 2) != 8'h00;
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt with no request");
endmodule // pic_chk
`default_nettype wire

/* bench/programmable_interrupt_controller_tb.sv */
// self-checking bench: host end drives device end over the pin bundle
`timescale 1ns/100ps
`default_nettype none
module programmable_interrupt_controller_tb;
  import pic_pkg::*;
  typedef struct packed {
    logic [7:0] req;
    logic [7:0] mask;
    logic irq;
    logic [7:0] vec;
  } pic_row_t;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [7:0] request_lines_in = 8'h00;
  logic master_select_in = 1'b1;
  logic [2:0] cascade_id_in = 3'h0;
  logic [2:0] cascade_id_out;
  logic cascade_out_valid_n_out;
  logic buffer_dir_out;
  logic buffer_dir_valid_n_out;
  logic valid_d = 1'b0;
  logic [15:0] rd_word;
  logic [2:0] cas_seen = 3'h0;
  logic [7:0] seen_q[$];
  logic [7:0] call_exp[3] = '{8'hCD, 8'h0C, 8'h40};
  int n_mismatch = 0;
  int tests_run = 0;
  // fixed priority after init: level 0 wins
  pic_row_t rows[5] = '{'{8'h01, 8'h00, 1'b1, 8'h40}, '{8'h80, 8'h00, 1'b1, 8'h47},
    '{8'h24, 8'h00, 1'b1, 8'h42}, '{8'h04, 8'h04, 1'b0, 8'h00}, '{8'h0C, 8'h04, 1'b1, 8'h43}};
  pic_if bus_if ();
  pic_host u_pic_host (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus(bus_if), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  pic_dev u_pic_dev (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus(bus_if),
    .request_lines_in(request_lines_in), .cascade_id_in(cascade_id_in),
    .master_select_in(master_select_in), .cascade_id_out(cascade_id_out),
    .cascade_out_valid_n_out(cascade_out_valid_n_out), .buffer_dir_out(buffer_dir_out),
    .buffer_dir_valid_n_out(buffer_dir_valid_n_out));
  pic_chk u_pic_chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .select_n(bus_if.select_n),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .ack_strobe_n(bus_if.ack_strobe_n), .read_bus(bus_if.read_bus),
    .read_bus_valid(bus_if.read_bus_valid), .int_req(bus_if.int_req),
    .request_lines_in(request_lines_in), .master_select_in(master_select_in),
    .cascade_out_valid_n_out(cascade_out_valid_n_out), .buffer_dir_out(buffer_dir_out));
  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // every byte the device drives is logged once, at the start of its valid window
  always @(posedge sys_clk_in) begin
    if (bus_if.read_bus_valid === 1'b1 && valid_d !== 1'b1) seen_q.push_back(bus_if.read_bus);
    valid_d <= bus_if.read_bus_valid;
  end
  // cascade id is only meaningful while its valid line is low
  always @(posedge sys_clk_in) begin
    if (cascade_out_valid_n_out === 1'b0) cas_seen <= cascade_id_out;
  end
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic host_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // orders are dropped while busy, so each one waits for idle
  task automatic order(input logic [3:0] a, input logic [8:0] d);
    logic [15:0] s;
    int n;
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= {7'h00, d};
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    n = 0;
    s = 16'h0001;
    while (s[0] !== 1'b0 && n < 40) begin
      host_rd(HREG_STATUS, s);
      n++;
    end
    check8("host idle", 8'h00, {7'h00, s[0]});
  endtask
  task automatic wr(input logic adr0, input logic [7:0] b);
    order(HREG_WRITE, {adr0, b});
  endtask
  task automatic ack(input logic call);
    seen_q.delete();
    order(HREG_ACK, {8'h00, call});
  endtask
  task automatic set_lines(input logic [7:0] v);
    @(posedge sys_clk_in);
    request_lines_in <= v;
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk_int(input logic e);
    check8("int_req", {7'h00, e}, {7'h00, bus_if.int_req});
  endtask
  task automatic init(input logic [7:0] icw1, input logic [7:0] icw4);
    wr(1'b0, icw1);
    wr(1'b1, 8'h40);
    if (icw1[0]) wr(1'b1, icw4);
    wr(1'b1, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_mismatch++;
    $display("BAD watchdog expected done seen running");
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    init(8'h13, 8'h01);
    foreach (rows[i]) begin
      wr(1'b1, rows[i].mask);
      set_lines(rows[i].req);
      chk_int(rows[i].irq);
      if (rows[i].irq) begin
        ack(1'b0);
        check8("vector", rows[i].vec, seen_q[$]);
        wr(1'b0, 8'h20);
      end
      set_lines(8'h00);
    end
    wr(1'b1, 8'h00);
    set_lines(8'h08);
    ack(1'b0);
    set_lines(8'h28);
    chk_int(1'b0);
    set_lines(8'h2A);
    chk_int(1'b1);
    ack(1'b0);
    check8("nested vector", 8'h41, seen_q[$]);
    wr(1'b0, 8'h20);
    wr(1'b0, 8'h20);
    set_lines(8'h00);
    wr(1'b1, 8'h10);
    set_lines(8'h10);
    wr(1'b0, 8'h0A);
    order(HREG_READ, 9'h000);
    check8("request status", 8'h10, seen_q[$]);
    order(HREG_READ, 9'h100);
    check8("mask status", 8'h10, seen_q[$]);
    set_lines(8'h00);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'hC2);
    set_lines(8'h0A);
    ack(1'b0);
    check8("rotated vector", 8'h43, seen_q[$]);
    wr(1'b0, 8'h20);
    set_lines(8'h00);
    init(8'h16, 8'h00);
    set_lines(8'h08);
    ack(1'b1);
    for (int i = 0; i < 3; i++) begin
      check8("call byte", call_exp[i], seen_q[i]);
      host_rd(HREG_BYTE0 + 4'(i), rd_word);
      check8("captured byte", call_exp[i], rd_word[7:0]);
    end
    wr(1'b0, 8'h20);
    set_lines(8'h00);
    // cascaded buffered master: the slave on level 3 owns the vector bytes
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h08);
    wr(1'b1, 8'h0D);
    wr(1'b1, 8'h00);
    check8("buffer valid", 8'h00, {7'h00, buffer_dir_valid_n_out});
    set_lines(8'h08);
    ack(1'b0);
    check8("cascade id", 8'h03, {5'h00, cas_seen});
    check8("master quiet", 8'h00, 8'(seen_q.size()));
    set_lines(8'h00);
    // second reset in mid-run: outputs must go quiet again
    @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    set_lines(8'h20);
    chk_int(1'b0);
    check8("cascade valid", 8'h01, {7'h00, cascade_out_valid_n_out});
    check8("buffer valid", 8'h01, {7'h00, buffer_dir_valid_n_out});
    seen_q.delete();
    order(HREG_READ, 9'h000);
    check8("early read", 8'h00, 8'(seen_q.size()));
    init(8'h13, 8'h01);
    chk_int(1'b0);
    init(8'h1B, 8'h01);
    set_lines(8'h20);
    chk_int(1'b1);
    tally_and_finish();
  end
endmodule // programmable_interrupt_controller_tb
`default_nettype wire
